//--- design/tsd_pkg.sv
// Constants shared by the tile status, security and debug register bank.
// Assumes a 32-bit status register data path addressed by register number.
package tsd_pkg;

   // ----------------------------------------------------------------
   // Register numbers
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_SECURITY = 8'h05;
   localparam logic [7:0] REG_OSC_CTRL = 8'h06;
   localparam logic [7:0] REG_CORE_CELL_CNT = 8'h07;
   localparam logic [7:0] REG_CORE_WIRE_CNT = 8'h08;
   localparam logic [7:0] REG_PERIPH_CELL_CNT = 8'h09;
   localparam logic [7:0] REG_PERIPH_WIRE_CNT = 8'h0a;
   localparam logic [7:0] REG_RAM_SIZE = 8'h0c;
   localparam logic [7:0] REG_DBG_STATUS = 8'h10;
   localparam logic [7:0] REG_DBG_PC = 8'h11;
   localparam logic [7:0] REG_DBG_SP = 8'h12;
   localparam logic [7:0] REG_DBG_THREAD_SEL = 8'h13;
   localparam logic [7:0] REG_DBG_REG_SEL = 8'h14;
   localparam logic [7:0] REG_DBG_CAUSE = 8'h15;

   // ----------------------------------------------------------------
   // Security configuration fields
   // ----------------------------------------------------------------
   localparam int SEC_WR_LOCK_BIT = 31;
   localparam int SEC_GLOBAL_DBG_BIT = 14;
   localparam int SEC_OTP_LOCK_ALL_BIT = 12;
   localparam int SEC_SECTOR_LO = 8;
   localparam int SEC_OTP_REDUND_BIT = 7;
   localparam int SEC_BOOT_OTP_BIT = 5;
   localparam int SEC_JTAG_CFG_BIT = 4;
   localparam int SEC_JTAG_TAP_BIT = 0;
   localparam logic [31:0] SEC_MASK = 32'h8000_5fb1;
   localparam logic [31:0] SEC_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Oscillator control fields
   // ----------------------------------------------------------------
   localparam int OSC_CORE_EN_BIT = 1;
   localparam int OSC_PERIPH_EN_BIT = 0;
   localparam logic [1:0] OSC_CTRL_RESET = 2'h0;
   localparam int OSC_CNT_W = 16;

   // ----------------------------------------------------------------
   // Debug capture fields
   // ----------------------------------------------------------------
   localparam int SSR_W = 11;
   localparam logic [10:0] SSR_CAPTURE_MASK = 11'h7df;
   localparam logic [10:0] SSR_WRITE_MASK = 11'h6df;
   localparam int THREAD_SEL_W = 8;
   localparam int REG_SEL_W = 5;
   localparam int CAUSE_CODE_LO = 0;
   localparam int CAUSE_THREAD_LO = 8;
   localparam int CAUSE_INDEX_LO = 16;
   localparam logic [31:0] CAUSE_MASK = 32'h0003_ff07;
   localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
   localparam logic [2:0] CAUSE_HOST = 3'h1;
   localparam logic [2:0] CAUSE_DEBUG_CALL = 3'h2;
   localparam logic [2:0] CAUSE_INSTR_BREAK = 3'h3;
   localparam logic [2:0] CAUSE_DATA_WATCH = 3'h4;
   localparam logic [2:0] CAUSE_RES_WATCH = 3'h5;
   localparam int TRIG_N = 4;

endpackage

//--- design/tsd_regs.sv
// Tile status register bank: security word, ring oscillator control and
// counters, RAM size and debugger capture registers.
// Assumes the core issues single-cycle status reads and writes on SYS_CLK,
// and that oscillator outputs arrive asynchronously on plain pins.
`timescale 1ns/100ps

module tsd_regs
   import tsd_pkg::*;
#(
   parameter logic [31:0] RAM_BYTES = 32'h0004_0000
) (
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Status register access from the core.
   input wire logic PS_WR,
   input wire logic PS_RD,
   input wire logic [7:0] PS_NUM,
   input wire logic [31:0] PS_WDATA,
   input wire logic PS_DEBUG_MODE,
   output logic [31:0] PS_RDATA,
   output logic PS_RVALID,
   // Security word from OTP.
   input wire logic OTP_SEC_LOAD,
   input wire logic [31:0] OTP_SEC_WORD,
   // Security controls.
   output logic SEC_GLOBAL_DEBUG_DIS,
   output logic SEC_JTAG_TAP_DIS,
   output logic SEC_OTP_LOCK_ALL,
   output logic [3:0] SEC_OTP_SECTOR_LOCK,
   output logic SEC_OTP_REDUNDANCY,
   output logic SEC_BOOT_FROM_OTP,
   output logic SEC_JTAG_CFG_DIS,
   // Ring oscillators.
   output logic OSC_CORE_EN,
   output logic OSC_PERIPH_EN,
   input wire logic [3:0] OSC_IN,
   // Debugger entry capture.
   input wire logic DBG_ENTRY,
   input wire logic [10:0] DBG_STATUS,
   input wire logic [31:0] DBG_PC,
   input wire logic [31:0] DBG_SP,
   input wire logic [2:0] DBG_CAUSE,
   input wire logic [7:0] DBG_THREAD,
   input wire logic [3:0] DBG_TRIG_HITS,
   // Debug register read operands.
   output logic [7:0] DBG_READ_THREAD,
   output logic [4:0] DBG_READ_REG
);

   // ----------------------------------------------------------------
   // Types and functions
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] sec;
      logic [1:0] osc_ctrl;
      logic [SSR_W-1:0] saved_status_word;
      logic [31:0] saved_program_counter;
      logic [31:0] saved_stack_pointer;
      logic [THREAD_SEL_W-1:0] thr_sel;
      logic [REG_SEL_W-1:0] reg_sel;
      logic [31:0] cause;
      logic [31:0] rdata;
      logic rvalid;
   } tsd_state_s;

   // Index of the lowest set trigger bit, zero when none is set.
   function automatic logic [1:0] tsd_lowest(input logic [TRIG_N-1:0] hits);
      logic [1:0] idx;
      idx = 2'h0;
      for (int i = TRIG_N - 1; i >= 0; i--) begin
         if (hits[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // Widens a counter to a register word, upper bits zero.
   function automatic logic [31:0] tsd_cnt_word(input logic [OSC_CNT_W-1:0] c);
      return {{(32 - OSC_CNT_W){1'b0}}, c};
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tsd_state_s st_r;
   tsd_state_s st_nxt;
   logic [3:0] osc_meta_r;
   logic [3:0] osc_sync_r;
   logic [3:0] osc_prev_r;
   logic [OSC_CNT_W-1:0] osc_cnt_r [4];
   logic [3:0] osc_en;
   logic wr_ok_dbg;
   logic [31:0] cause_cap;

   // Core oscillators are 0 and 1, peripheral ones are 2 and 3.
   assign osc_en = {{2{st_r.osc_ctrl[OSC_PERIPH_EN_BIT]}}, {2{st_r.osc_ctrl[OSC_CORE_EN_BIT]}}};

   // Debug registers take writes only while the core runs debug code.
   assign wr_ok_dbg = PS_WR & PS_DEBUG_MODE;

   // ----------------------------------------------------------------
   // Ring oscillator counters
   // ----------------------------------------------------------------
   // Two-stage synchroniser.
   // The oscillator pins are asynchronous; only the second stage and the
   // edge history behind it feed the counters. Counting in this domain
   // limits the usable oscillator rate to below half of SYS_CLK.
   // No reset here.
   // Counters keep their count across a system reset on purpose, which
   // is why they sit outside the reset process.
   always_ff @(posedge SYS_CLK) begin
      osc_meta_r <= OSC_IN;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
      for (int i = 0; i < 4; i++) begin
         if (osc_en[i] && osc_sync_r[i] && !osc_prev_r[i]) begin
            osc_cnt_r[i] <= osc_cnt_r[i] + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Debug cause capture
   // ----------------------------------------------------------------
   // Builds the cause word seen at debugger entry.
   always_comb begin
      cause_cap = 32'h0000_0000;
      cause_cap[CAUSE_CODE_LO +: 3] = DBG_CAUSE;
      if (DBG_CAUSE != CAUSE_HOST) begin
         cause_cap[CAUSE_THREAD_LO +: 8] = DBG_THREAD;
      end
      // Lowest trigger index.
      // Host requests and debug calls have no hardware trigger.
      if (DBG_CAUSE == CAUSE_INSTR_BREAK || DBG_CAUSE == CAUSE_DATA_WATCH ||
          DBG_CAUSE == CAUSE_RES_WATCH) begin
         cause_cap[CAUSE_INDEX_LO +: 2] = tsd_lowest(DBG_TRIG_HITS);
      end
   end

   // ----------------------------------------------------------------
   // Register next state
   // ----------------------------------------------------------------
   // Writes, reads and captures. Capture and OTP load are placed after
   // the software write so that a hardware update in the same cycle wins.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = 1'b0;
      if (PS_WR) begin
         case (PS_NUM)
            REG_SECURITY: begin
               if (!st_r.sec[SEC_WR_LOCK_BIT]) begin
                  st_nxt.sec = PS_WDATA & SEC_MASK;
               end
            end
            REG_OSC_CTRL: begin
               st_nxt.osc_ctrl = PS_WDATA[1:0];
            end
            REG_DBG_STATUS: begin
               if (wr_ok_dbg) begin
                  st_nxt.saved_status_word = (PS_WDATA[SSR_W-1:0] & SSR_WRITE_MASK) |
                               (st_r.saved_status_word & ~SSR_WRITE_MASK);
               end
            end
            REG_DBG_PC: begin
               if (wr_ok_dbg) begin
                  st_nxt.saved_program_counter = PS_WDATA;
               end
            end
            REG_DBG_SP: begin
               if (wr_ok_dbg) begin
                  st_nxt.saved_stack_pointer = PS_WDATA;
               end
            end
            REG_DBG_THREAD_SEL: begin
               if (wr_ok_dbg) begin
                  st_nxt.thr_sel = PS_WDATA[THREAD_SEL_W-1:0];
               end
            end
            REG_DBG_REG_SEL: begin
               if (wr_ok_dbg) begin
                  st_nxt.reg_sel = PS_WDATA[REG_SEL_W-1:0];
               end
            end
            REG_DBG_CAUSE: begin
               if (wr_ok_dbg) begin
                  st_nxt.cause = PS_WDATA & CAUSE_MASK;
               end
            end
            default: begin
               st_nxt.rvalid = 1'b0;
            end
         endcase
      end
      // Load from OTP.
      // The OTP copy is taken even when the write lock is set.
      if (OTP_SEC_LOAD) begin
         st_nxt.sec = OTP_SEC_WORD & SEC_MASK;
      end
      if (DBG_ENTRY) begin
         st_nxt.saved_status_word = DBG_STATUS & SSR_CAPTURE_MASK;
         st_nxt.saved_program_counter = DBG_PC;
         st_nxt.saved_stack_pointer = DBG_SP;
         st_nxt.cause = cause_cap;
      end
      // Read answer one cycle after the request, unmapped numbers read zero.
      if (PS_RD) begin
         st_nxt.rvalid = 1'b1;
         case (PS_NUM)
            REG_SECURITY: begin
               st_nxt.rdata = st_r.sec;
            end
            REG_OSC_CTRL: begin
               st_nxt.rdata = {30'h0000_0000, st_r.osc_ctrl};
            end
            // Stable only ten cycles after a stop; not enforced here.
            REG_CORE_CELL_CNT: begin
               st_nxt.rdata = tsd_cnt_word(osc_cnt_r[0]);
            end
            REG_CORE_WIRE_CNT: begin
               st_nxt.rdata = tsd_cnt_word(osc_cnt_r[1]);
            end
            REG_PERIPH_CELL_CNT: begin
               st_nxt.rdata = tsd_cnt_word(osc_cnt_r[2]);
            end
            REG_PERIPH_WIRE_CNT: begin
               st_nxt.rdata = tsd_cnt_word(osc_cnt_r[3]);
            end
            REG_RAM_SIZE: begin
               st_nxt.rdata = {RAM_BYTES[31:2], 2'h0};
            end
            REG_DBG_STATUS: begin
               st_nxt.rdata = {21'h00_0000, st_r.saved_status_word};
            end
            REG_DBG_PC: begin
               st_nxt.rdata = st_r.saved_program_counter;
            end
            REG_DBG_SP: begin
               st_nxt.rdata = st_r.saved_stack_pointer;
            end
            REG_DBG_THREAD_SEL: begin
               st_nxt.rdata = {24'h00_0000, st_r.thr_sel};
            end
            REG_DBG_REG_SEL: begin
               st_nxt.rdata = {27'h000_0000, st_r.reg_sel};
            end
            REG_DBG_CAUSE: begin
               st_nxt.rdata = st_r.cause;
            end
            default: begin
               st_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // All control state resets to zero; the OTP load follows reset.
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Every output is a register bit or field of the state.
   assign PS_RDATA = st_r.rdata;
   assign PS_RVALID = st_r.rvalid;
   assign SEC_GLOBAL_DEBUG_DIS = st_r.sec[SEC_GLOBAL_DBG_BIT];
   assign SEC_JTAG_TAP_DIS = st_r.sec[SEC_JTAG_TAP_BIT];
   assign SEC_OTP_LOCK_ALL = st_r.sec[SEC_OTP_LOCK_ALL_BIT];
   assign SEC_OTP_SECTOR_LOCK = st_r.sec[SEC_SECTOR_LO +: 4];
   assign SEC_OTP_REDUNDANCY = st_r.sec[SEC_OTP_REDUND_BIT];
   assign SEC_BOOT_FROM_OTP = st_r.sec[SEC_BOOT_OTP_BIT];
   assign SEC_JTAG_CFG_DIS = st_r.sec[SEC_JTAG_CFG_BIT];
   assign OSC_CORE_EN = st_r.osc_ctrl[OSC_CORE_EN_BIT];
   assign OSC_PERIPH_EN = st_r.osc_ctrl[OSC_PERIPH_EN_BIT];
   assign DBG_READ_THREAD = st_r.thr_sel;
   assign DBG_READ_REG = st_r.reg_sel;

endmodule

//--- tb/tile_status_security_debug_regs_tb.sv
// Self-checking bench for the tile status register bank.
// Assumes tsd_regs with its checker bound and the core model beside it.
`timescale 1ns/100ps
module tile_status_security_debug_regs_tb;
   import tsd_pkg::*;
   localparam logic [31:0] RAM_B = 32'h0001_2347;
   logic SYS_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic PS_WR, PS_RD, PS_DEBUG_MODE, PS_RVALID, OTP_SEC_LOAD, DBG_ENTRY;
   logic SEC_GLOBAL_DEBUG_DIS, SEC_JTAG_TAP_DIS, SEC_OTP_LOCK_ALL, SEC_OTP_REDUNDANCY;
   logic SEC_BOOT_FROM_OTP, SEC_JTAG_CFG_DIS, OSC_CORE_EN, OSC_PERIPH_EN;
   logic [7:0] PS_NUM, DBG_THREAD, DBG_READ_THREAD;
   logic [31:0] PS_WDATA, PS_RDATA, OTP_SEC_WORD, DBG_PC, DBG_SP, w;
   logic [3:0] SEC_OTP_SECTOR_LOCK, DBG_TRIG_HITS;
   logic [3:0] OSC_IN = 4'h5;
   logic [10:0] DBG_STATUS;
   logic [2:0] DBG_CAUSE;
   logic [4:0] DBG_READ_REG;
   int n_errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   // Clock and slow free-running oscillator pins, unrelated in phase.
   always #2.5 SYS_CLK = ~SYS_CLK;
   always #13 OSC_IN = ~OSC_IN;

   tsd_regs #(.RAM_BYTES(RAM_B)) dut (.*);
   tsd_core_model core (.clk(SYS_CLK), .rdata(PS_RDATA), .rvalid(PS_RVALID), .wr(PS_WR),
      .rd(PS_RD), .num(PS_NUM), .wdata(PS_WDATA), .dbg_mode(PS_DEBUG_MODE));

   // Expected cause word: host clears thread, lowest hit only for triggers.
   function automatic logic [31:0] exp_cause(logic [2:0] c, logic [7:0] t, logic [3:0] h);
      logic [1:0] ix;
      ix = 2'd0;
      if (c >= CAUSE_INSTR_BREAK)
         for (int i = 3; i >= 0; i--)
            if (h[i])
               ix = 2'(i);
      return {14'h0, ix, (c == CAUSE_HOST) ? 8'h00 : t, 5'h0, c};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
      cmp_count++;
      if ((got & m) !== (exp & m)) begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] n, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] d;
      logic ok;
      core.ps_read(n, d, ok);
      chk({31'h0, ok}, 32'h1, 32'h1);
      chk(d, exp, m);
   endtask

   // Security outputs laid out at their register bit positions.
   task automatic sec_outs(input logic [31:0] e);
      chk({17'h0, SEC_GLOBAL_DEBUG_DIS, 1'b0, SEC_OTP_LOCK_ALL, SEC_OTP_SECTOR_LOCK,
         SEC_OTP_REDUNDANCY, 1'b0, SEC_BOOT_FROM_OTP, SEC_JTAG_CFG_DIS, 3'h0,
         SEC_JTAG_TAP_DIS}, e, 32'h0000_5fb1);
   endtask

   task automatic otp_load(input logic [31:0] v);
      @(negedge SYS_CLK);
      OTP_SEC_WORD = v;
      OTP_SEC_LOAD = 1'b1;
      @(negedge SYS_CLK);
      OTP_SEC_LOAD = 1'b0;
   endtask

   task automatic capture(input logic [2:0] c, input logic [3:0] h);
      @(negedge SYS_CLK);
      {DBG_CAUSE, DBG_TRIG_HITS, DBG_THREAD} = {c, h, 8'($urandom)};
      {DBG_STATUS, DBG_PC, DBG_SP} = {11'($urandom), $urandom, $urandom};
      DBG_ENTRY = 1'b1;
      @(negedge SYS_CLK);
      DBG_ENTRY = 1'b0;
      rchk(REG_DBG_STATUS, {21'h0, DBG_STATUS & SSR_CAPTURE_MASK}, '1);
      rchk(REG_DBG_PC, DBG_PC, '1);
      rchk(REG_DBG_SP, DBG_SP, '1);
      rchk(REG_DBG_CAUSE, exp_cause(c, DBG_THREAD, h), '1);
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard, well above the roughly 150 cycles the tests need.
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         wrap_up();
      end
   end

   initial begin
      {OTP_SEC_LOAD, OTP_SEC_WORD, DBG_ENTRY, DBG_STATUS, DBG_PC, DBG_SP} = '0;
      {DBG_CAUSE, DBG_THREAD, DBG_TRIG_HITS} = '0;
      void'($urandom(32'h5f0a));
      repeat (4) @(posedge SYS_CLK);
      @(negedge SYS_CLK);
      SYS_RST = 1'b0;
      rchk(REG_RAM_SIZE, {RAM_B[31:2], 2'b00}, '1);
      rchk(REG_SECURITY, SEC_RESET, '1);
      rchk(REG_OSC_CTRL, 32'h0, '1);
      rchk(REG_DBG_CAUSE, CAUSE_RESET, '1);
      rchk(8'h0b, 32'h0, '1);
      // Load, software update, lock, refused write, then a reload.
      w = $urandom & 32'h7fff_ffff;
      otp_load(w);
      rchk(REG_SECURITY, w & SEC_MASK, '1);
      sec_outs(w);
      w = $urandom & 32'h7fff_ffff;
      core.ps_write(REG_SECURITY, w);
      rchk(REG_SECURITY, w & SEC_MASK, '1);
      sec_outs(w);
      w = w | 32'h8000_0000;
      core.ps_write(REG_SECURITY, w);
      core.ps_write(REG_SECURITY, 32'h0000_0000);
      rchk(REG_SECURITY, w & SEC_MASK, '1);
      otp_load(32'h0000_0000);
      rchk(REG_SECURITY, 32'h0, '1);
      // Every enable combination, noise in reserved bits.
      for (int i = 0; i < 5; i++) begin
         w = {30'($urandom), 2'(i)};
         core.ps_write(REG_OSC_CTRL, w);
         rchk(REG_OSC_CTRL, {30'h0, w[1:0]}, '1);
         chk({30'h0, OSC_CORE_EN, OSC_PERIPH_EN}, w, 32'h3);
      end
      core.settle();
      for (int n = 7; n <= 10; n++)
         rchk(8'(n), 32'h0, 32'hffff_0000);
      // Every cause code; a trigger with no hit and one with two.
      for (int c = 1; c <= 5; c++)
         capture(3'(c), (c == 3) ? 4'h0 : 4'($urandom));
      capture(CAUSE_DATA_WATCH, 4'hc);
      core.ps_write(REG_DBG_THREAD_SEL, 32'hffff_ffff);
      rchk(REG_DBG_THREAD_SEL, 32'h0, '1);
      core.set_mode(1'b1);
      w = $urandom;
      core.ps_write(REG_DBG_THREAD_SEL, w);
      core.ps_write(REG_DBG_REG_SEL, w);
      core.ps_write(REG_DBG_STATUS, w);
      core.ps_write(REG_DBG_PC, w);
      rchk(REG_DBG_THREAD_SEL, {24'h0, w[7:0]}, '1);
      rchk(REG_DBG_REG_SEL, {27'h0, w[4:0]}, '1);
      chk({19'h0, DBG_READ_REG, DBG_READ_THREAD}, {19'h0, w[4:0], w[7:0]}, 32'h1fff);
      rchk(REG_DBG_STATUS, {21'h0, (DBG_STATUS & 11'h100) | (w[10:0] & SSR_WRITE_MASK)}, '1);
      rchk(REG_DBG_PC, w, '1);
      wrap_up();
   end
endmodule

//--- tb/tsd_core_model.sv
// Model of the core issuing numbered status reads and writes.
// Assumes a read is answered one cycle after its strobe.
`timescale 1ns/100ps
module tsd_core_model (
   // Clock and bank answer.
   input wire logic clk,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   // Requests to the bank.
   output logic wr,
   output logic rd,
   output logic [7:0] num,
   output logic [31:0] wdata,
   output logic dbg_mode
);
   initial begin
      wr = 1'b0;
      rd = 1'b0;
      num = 8'h00;
      wdata = 32'h0000_0000;
      dbg_mode = 1'b0;
   end

   // numbered write; data is scrambled once released.
   task automatic ps_write(input logic [7:0] n, input logic [31:0] d);
      @(negedge clk);
      num = n;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      wdata = ~d;
   endtask

   // numbered read, answer taken in the answer cycle.
   task automatic ps_read(input logic [7:0] n, output logic [31:0] d, output logic ok);
      @(negedge clk);
      num = n;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = rdata;
      ok = rvalid;
   endtask

   // debug mode; the debugger sets it before writing operands.
   task automatic set_mode(input logic m);
      @(negedge clk);
      dbg_mode = m;
   endtask

   // wait after stopping oscillators before reading counts.
   task automatic settle();
      repeat (10) @(posedge clk);
   endtask
endmodule

//--- tb/tsd_regs_props.sv
// Port-level checks for the tile status register bank.
// Assumes it is bound onto tsd_regs and shares its RAM_BYTES value.
`timescale 1ns/100ps
module tsd_regs_props
   import tsd_pkg::*;
#(
   parameter logic [31:0] RAM_BYTES = 32'h0004_0000
) (
   // Clock, reset and status bus.
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic PS_WR,
   input wire logic PS_RD,
   input wire logic [7:0] PS_NUM,
   input wire logic [31:0] PS_WDATA,
   input wire logic PS_DEBUG_MODE,
   input wire logic [31:0] PS_RDATA,
   input wire logic PS_RVALID,
   // Security, oscillator and debug thread select controls.
   input wire logic OTP_SEC_LOAD,
   input wire logic [31:0] OTP_SEC_WORD,
   input wire logic SEC_GLOBAL_DEBUG_DIS,
   input wire logic SEC_JTAG_TAP_DIS,
   input wire logic SEC_OTP_LOCK_ALL,
   input wire logic [3:0] SEC_OTP_SECTOR_LOCK,
   input wire logic SEC_OTP_REDUNDANCY,
   input wire logic SEC_BOOT_FROM_OTP,
   input wire logic SEC_JTAG_CFG_DIS,
   input wire logic OSC_CORE_EN,
   input wire logic OSC_PERIPH_EN,
   input wire logic [7:0] DBG_READ_THREAD
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   // Read requests and debug-mode writes, shared by several checks.
   sequence rd_of(n);
      PS_RD && PS_NUM == n;
   endsequence
   sequence dwr_of(n);
      PS_WR && PS_DEBUG_MODE && PS_NUM == n;
   endsequence

   AST_RVALID: assert property (PS_RD |=> PS_RVALID)
      else $error("read not answered");
   AST_NO_RVALID: assert property (!PS_RD |=> !PS_RVALID)
      else $error("answer without read");
   AST_RAM_SIZE: assert property (rd_of(REG_RAM_SIZE) |=> PS_RDATA == {RAM_BYTES[31:2], 2'b00})
      else $error("ram size wrong");
   AST_OSC_RSVD: assert property (rd_of(REG_OSC_CTRL) |=> PS_RDATA[31:2] == 30'h0)
      else $error("reserved bits set");
   AST_OTP_DBG: assert property (OTP_SEC_LOAD |=> SEC_GLOBAL_DEBUG_DIS == $past(OTP_SEC_WORD[14])
      && SEC_JTAG_TAP_DIS == $past(OTP_SEC_WORD[0]))
      else $error("debug disables not loaded");
   AST_OTP_FIELDS: assert property (OTP_SEC_LOAD |=> {SEC_OTP_LOCK_ALL, SEC_OTP_SECTOR_LOCK,
      SEC_OTP_REDUNDANCY, SEC_BOOT_FROM_OTP, SEC_JTAG_CFG_DIS} == {$past(OTP_SEC_WORD[12:7]),
      $past(OTP_SEC_WORD[5:4])})
      else $error("otp fields not loaded");
   AST_SEC_HOLD: assert property (!OTP_SEC_LOAD && !PS_WR |=> $stable(SEC_GLOBAL_DEBUG_DIS))
      else $error("security changed alone");
   AST_OSC_WR: assert property (PS_WR && PS_NUM == REG_OSC_CTRL
      |=> {OSC_CORE_EN, OSC_PERIPH_EN} == $past(PS_WDATA[1:0]))
      else $error("oscillator enables wrong");
   AST_OSC_RST: assert property (disable iff (1'b0) SYS_RST |=> !OSC_CORE_EN && !OSC_PERIPH_EN)
      else $error("enables not cleared in reset");
   AST_THREAD_SEL: assert property (dwr_of(REG_DBG_THREAD_SEL)
      |=> DBG_READ_THREAD == $past(PS_WDATA[7:0]))
      else $error("thread select wrong");
   AST_DBG_LOCK: assert property (PS_WR && !PS_DEBUG_MODE |=> $stable(DBG_READ_THREAD))
      else $error("debug write outside debug");
endmodule

bind tsd_regs tsd_regs_props #(.RAM_BYTES(RAM_BYTES)) u_props (.*);
